//--- common/afm_map.vh
// Register map, field positions, reset values and timing counts
// of the amplifier fault manager. Definitions only.
`ifndef AFM_MAP_VH
`define AFM_MAP_VH

// ----------------------------------------------------------------
// Register offsets (byte addresses, one 32-bit word each)
// ----------------------------------------------------------------
`define AFM_ADR_CTRL 8'h00
`define AFM_ADR_STATUS 8'h04
`define AFM_ADR_INT_STATUS 8'h08
`define AFM_ADR_INT_MASK 8'h0C

// ----------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------
`define AFM_CTRL_SHUTDOWN_N 0
`define AFM_CTRL_PBTL 1
`define AFM_CTRL_FREQ_8X 2
`define AFM_CTRL_RESET 3'h1

// ----------------------------------------------------------------
// Error bits shared by status, interrupt status and mask, then status-only bits
// ----------------------------------------------------------------
`define AFM_ERR_OV 0
`define AFM_ERR_UV 1
`define AFM_ERR_CLK 2
`define AFM_ERR_OC 3
`define AFM_ERR_DC 4
`define AFM_ERR_OT 5
`define AFM_ERR_W 6
`define AFM_ST_FAULT 6
`define AFM_ST_AMP_EN 7
`define AFM_ST_HW_MODE 8
`define AFM_ST_W 9

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define AFM_CLK_HZ 10000000
`define AFM_DC_PERSIST_MS 420
`define AFM_DC_PERSIST_CYC (`AFM_DC_PERSIST_MS * (`AFM_CLK_HZ / 1000))
`define AFM_DC_DUTY_PCT 60
`define AFM_DC_WIN_CYC 256
`define AFM_FAULT_TIMEOUT_CYC 10000

`endif

//--- rtl/afm_dc_detect.v
// Differential duty-cycle DC detector for one output channel.
// Assumes pos_i/neg_i are already synchronised to clk_i.
`timescale 1ns/10ps
module afm_dc_detect #(
  parameter WIN_CYC = 256,
  parameter DUTY_PCT = 60,
  parameter PERSIST_CYC = 4200000
) (
  // Clock and reset
  input wire clk_i,
  input wire arst_n_i,
  // Output stage polarity
  input wire pos_i,
  input wire neg_i,
  // Result
  output reg dc_o
);

  localparam [15:0] WIN_LAST = WIN_CYC - 1;
  localparam [15:0] THR = (WIN_CYC * DUTY_PCT) / 100;
  localparam [23:0] PERSIST = PERSIST_CYC;
  localparam [23:0] WIN24 = WIN_CYC;

  reg [15:0] win_reg;
  reg [15:0] pos_reg;
  reg [15:0] neg_reg;
  reg [23:0] run_reg;
  reg pol_reg;
  reg act_reg;
  wire win_end = (win_reg == WIN_LAST);
  wire pos_tot = pos_i & ~neg_i;
  wire neg_tot = neg_i & ~pos_i;
  wire [15:0] pos_fin = pos_reg + {15'h0000, pos_tot};
  wire [15:0] neg_fin = neg_reg + {15'h0000, neg_tot};
  wire hi_pos = (pos_fin > THR);
  wire hi_neg = (neg_fin > THR);

  // ----------------------------------------------------------------
  // Window duty measurement and polarity persistence
  // ----------------------------------------------------------------
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      win_reg <= 16'h0000;
      pos_reg <= 16'h0000;
      neg_reg <= 16'h0000;
      run_reg <= 24'h000000;
      pol_reg <= 1'b0;
      act_reg <= 1'b0;
      dc_o <= 1'b0;
    end else begin
      if (win_end) begin
        win_reg <= 16'h0000;
        pos_reg <= 16'h0000;
        neg_reg <= 16'h0000;
        // Same polarity above threshold extends the run
        if ((hi_pos || hi_neg) && act_reg && (pol_reg == hi_pos)) begin
          if (run_reg <= PERSIST) begin
            run_reg <= run_reg + WIN24;
          end
        end else if (hi_pos || hi_neg) begin
          run_reg <= WIN24;
          pol_reg <= hi_pos;
          act_reg <= 1'b1;
        end else begin
          run_reg <= 24'h000000;
          act_reg <= 1'b0;
        end
      end else begin
        win_reg <= win_reg + 16'h0001;
        pos_reg <= pos_fin;
        neg_reg <= neg_fin;
      end
      // Strictly longer than the persistence interval
      dc_o <= act_reg && (run_reg > PERSIST);
    end
  end

endmodule // afm_dc_detect

//--- rtl/afm_fault_manager.v
// Fault classification, open-drain fault pin and Wishbone registers
// of a stereo class-D amplifier. Error flags come from analog
// comparators outside; all input pins except the Wishbone bus are asynchronous to CLK_I.
`timescale 1ns/10ps
`include "afm_map.vh"
module afm_fault_manager #(
  parameter FAULT_TIMEOUT_CYC = `AFM_FAULT_TIMEOUT_CYC,
  parameter DC_PERSIST_CYC = `AFM_DC_PERSIST_CYC,
  parameter DC_WIN_CYC = `AFM_DC_WIN_CYC
) (
  // Clock and reset
  input wire CLK_I,
  input wire ARST_N_I,
  // Wishbone slave
  input wire CYC_I,
  input wire STB_I,
  input wire WE_I,
  input wire [7:0] ADR_I,
  input wire [3:0] SEL_I,
  input wire [31:0] DAT_I,
  output reg [31:0] DAT_O,
  output reg ACK_O,
  // Straps
  input wire MODE_HW_I,
  input wire PBTL_I,
  input wire FREQ_8X_I,
  // Shutdown pin
  input wire AMP_SHUTDOWN_N_I,
  // Protection comparators
  input wire OVERVOLTAGE_I,
  input wire UNDERVOLTAGE_I,
  input wire OVERCURRENT_I,
  input wire OVERTEMP_I,
  input wire OVERTEMP_HYST_I,
  // Clock monitor
  input wire CLK_RATIO_BAD_I,
  input wire CLK_RATE_BAD_I,
  input wire CLK_STOPPED_I,
  // Output stage polarity per channel
  input wire [1:0] PWM_POS_I,
  input wire [1:0] PWM_NEG_I,
  // Fault pin, open drain
  output wire AMP_FAULT_N_O,
  output reg AMP_FAULT_N_OE_O,
  // Amplifier control
  output reg AMP_ENABLE_O,
  output reg CFG_PBTL_O,
  output reg CFG_FREQ_8X_O,
  // Interrupt
  output reg IRQ_O
);

  localparam NSYNC = 16;
  localparam [23:0] TMO = FAULT_TIMEOUT_CYC;

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  wire [NSYNC-1:0] async_in = {PWM_NEG_I, PWM_POS_I, FREQ_8X_I, PBTL_I, MODE_HW_I,
    CLK_STOPPED_I, CLK_RATE_BAD_I, CLK_RATIO_BAD_I, OVERTEMP_HYST_I, OVERTEMP_I,
    OVERCURRENT_I, UNDERVOLTAGE_I, OVERVOLTAGE_I, AMP_SHUTDOWN_N_I};
  reg [NSYNC-1:0] meta_reg;
  reg [NSYNC-1:0] sync_reg;

  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi = gi + 1) begin : g_sync
      always @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
          meta_reg[gi] <= 1'b0;
          sync_reg[gi] <= 1'b0;
        end else begin
          meta_reg[gi] <= async_in[gi];
          sync_reg[gi] <= meta_reg[gi];
        end
      end
    end
  endgenerate

  wire sd_pin = sync_reg[0];
  wire ov = sync_reg[1];
  wire uv = sync_reg[2];
  wire oc = sync_reg[3];
  wire ot = sync_reg[4];
  wire ot_hyst = sync_reg[5];
  wire clk_err = sync_reg[6] | sync_reg[7] | sync_reg[8];
  wire strap_hw = sync_reg[9];
  wire strap_pbtl = sync_reg[10];
  wire strap_f8x = sync_reg[11];
  wire [1:0] pos_s = sync_reg[13:12];
  wire [1:0] neg_s = sync_reg[15:14];

  // ----------------------------------------------------------------
  // Strap capture after reset release
  // ----------------------------------------------------------------
  // Straps are only trusted once both sync stages hold pin values
  reg [1:0] start_reg;
  reg hw_mode_reg;
  always @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      start_reg <= 2'h0;
      hw_mode_reg <= 1'b0;
    end else if (start_reg != 2'h3) begin
      start_reg <= start_reg + 2'h1;
      if (start_reg == 2'h2) begin
        hw_mode_reg <= strap_hw;
      end
    end
  end
  wire started = (start_reg == 2'h3);

  // ----------------------------------------------------------------
  // DC detectors
  // ----------------------------------------------------------------
  wire [1:0] dc_ch;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_dc
      afm_dc_detect #(
        .WIN_CYC(DC_WIN_CYC),
        .DUTY_PCT(`AFM_DC_DUTY_PCT),
        .PERSIST_CYC(DC_PERSIST_CYC)
      ) u_dc (
        .clk_i(CLK_I),
        .arst_n_i(ARST_N_I),
        .pos_i(pos_s[gi]),
        .neg_i(neg_s[gi]),
        .dc_o(dc_ch[gi])
      );
    end
  endgenerate
  wire dc_any = |dc_ch;

  // ----------------------------------------------------------------
  // Wishbone decode
  // ----------------------------------------------------------------
  function hit;
    input [7:0] adr;
    input [7:0] off;
    begin
      hit = (adr[7:2] == off[7:2]);
    end
  endfunction

  wire wb_req = CYC_I & STB_I & ~ACK_O;
  wire wb_wr = wb_req & WE_I & SEL_I[0];
  wire wr_ctrl = wb_wr & hit(ADR_I, `AFM_ADR_CTRL);
  wire wr_ist = wb_wr & hit(ADR_I, `AFM_ADR_INT_STATUS);
  wire wr_imask = wb_wr & hit(ADR_I, `AFM_ADR_INT_MASK);

  reg [2:0] ctrl_reg;
  always @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      ctrl_reg <= `AFM_CTRL_RESET;
    end else if (wr_ctrl && !hw_mode_reg) begin
      ctrl_reg <= DAT_I[2:0];
    end
  end

  // Shutdown bit only counts in software mode
  wire sd_eff = sd_pin & (hw_mode_reg | ctrl_reg[`AFM_CTRL_SHUTDOWN_N]);

  // ----------------------------------------------------------------
  // Latching errors and fault timeout
  // ----------------------------------------------------------------
  reg oc_lat_reg;
  reg dc_lat_reg;
  reg ot_lat_reg;
  reg sd_low_seen_reg;
  reg [23:0] tmr_reg;
  wire lat_any = oc_lat_reg | dc_lat_reg | ot_lat_reg;
  wire tmr_done = (tmr_reg >= TMO);
  // Released while shutdown may still be low, so a fault pin tied
  // to the shutdown pin can free itself after the timeout
  wire lat_clear = lat_any & tmr_done & sd_low_seen_reg & ~(ot_lat_reg & ot_hyst);

  always @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      oc_lat_reg <= 1'b0;
      dc_lat_reg <= 1'b0;
      ot_lat_reg <= 1'b0;
      sd_low_seen_reg <= 1'b0;
      tmr_reg <= 24'h000000;
    end else if (started) begin
      if (lat_clear) begin
        // Errors still present latch again next cycle out of shutdown
        oc_lat_reg <= 1'b0;
        dc_lat_reg <= 1'b0;
        ot_lat_reg <= 1'b0;
        sd_low_seen_reg <= 1'b0;
        tmr_reg <= 24'h000000;
      end else begin
        // Detection only while out of shutdown
        if (sd_eff) begin
          oc_lat_reg <= oc_lat_reg | oc;
          dc_lat_reg <= dc_lat_reg | dc_any;
          ot_lat_reg <= ot_lat_reg | ot;
        end
        if (lat_any) begin
          if (!sd_eff) begin
            sd_low_seen_reg <= 1'b1;
          end
          if (!tmr_done) begin
            tmr_reg <= tmr_reg + 24'h000001;
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Fault pin and amplifier enable
  // ----------------------------------------------------------------
  assign AMP_FAULT_N_O = 1'b0;
  always @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      AMP_FAULT_N_OE_O <= 1'b0;
      AMP_ENABLE_O <= 1'b0;
      CFG_PBTL_O <= 1'b0;
      CFG_FREQ_8X_O <= 1'b0;
    end else begin
      // Only latched and clock errors pull the line
      AMP_FAULT_N_OE_O <= started & (lat_any | clk_err);
      // Voltage and clock errors mute without latching
      AMP_ENABLE_O <= started & sd_eff & ~lat_any & ~clk_err & ~ov & ~uv;
      if (hw_mode_reg) begin
        CFG_PBTL_O <= strap_pbtl;
        CFG_FREQ_8X_O <= strap_f8x;
      end else begin
        CFG_PBTL_O <= ctrl_reg[`AFM_CTRL_PBTL];
        CFG_FREQ_8X_O <= ctrl_reg[`AFM_CTRL_FREQ_8X];
      end
    end
  end

  // ----------------------------------------------------------------
  // Status and interrupts
  // ----------------------------------------------------------------
  wire [`AFM_ERR_W-1:0] err_now = {ot_lat_reg, dc_lat_reg, oc_lat_reg, clk_err, uv, ov};
  wire [`AFM_ST_W-1:0] status = {hw_mode_reg, AMP_ENABLE_O, AMP_FAULT_N_OE_O, err_now};
  reg [`AFM_ERR_W-1:0] err_prev_reg;
  reg [`AFM_ERR_W-1:0] ist_reg;
  reg [`AFM_ERR_W-1:0] imask_reg;
  wire [`AFM_ERR_W-1:0] err_rise = err_now & ~err_prev_reg & {`AFM_ERR_W{started}};
  wire [`AFM_ERR_W-1:0] ist_clr = wr_ist ? DAT_I[`AFM_ERR_W-1:0] : {`AFM_ERR_W{1'b0}};

  always @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      err_prev_reg <= {`AFM_ERR_W{1'b0}};
      ist_reg <= {`AFM_ERR_W{1'b0}};
      imask_reg <= {`AFM_ERR_W{1'b0}};
      IRQ_O <= 1'b0;
    end else begin
      err_prev_reg <= err_now;
      // A new event wins over a clear in the same cycle
      ist_reg <= (ist_reg & ~ist_clr) | err_rise;
      if (wr_imask) begin
        imask_reg <= DAT_I[`AFM_ERR_W-1:0];
      end
      IRQ_O <= |(ist_reg & imask_reg);
    end
  end

  // ----------------------------------------------------------------
  // Read data and acknowledge
  // ----------------------------------------------------------------
  always @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      ACK_O <= 1'b0;
      DAT_O <= 32'h00000000;
    end else begin
      ACK_O <= wb_req;
      if (wb_req && !WE_I) begin
        if (hit(ADR_I, `AFM_ADR_CTRL)) begin
          DAT_O <= {29'h00000000, ctrl_reg};
        end else if (hit(ADR_I, `AFM_ADR_STATUS)) begin
          DAT_O <= {23'h000000, status};
        end else if (hit(ADR_I, `AFM_ADR_INT_STATUS)) begin
          DAT_O <= {26'h0000000, ist_reg};
        end else if (hit(ADR_I, `AFM_ADR_INT_MASK)) begin
          DAT_O <= {26'h0000000, imask_reg};
        end else begin
          DAT_O <= 32'h00000000;
        end
      end
    end
  end

endmodule // afm_fault_manager

//--- bench/afm_fault_manager_sva.sv
// Port checker for the amplifier fault manager, bound to its top.
// Assumes CLK_I only and an asynchronous active-low ARST_N_I.
`timescale 1ns/10ps
module afm_fault_manager_sva #(
  parameter FAULT_TIMEOUT_CYC = 20
) (
  // Clock and reset
  input wire CLK_I,
  input wire ARST_N_I,
  // Bus
  input wire CYC_I,
  input wire STB_I,
  input wire WE_I,
  input wire ACK_O,
  input wire [31:0] DAT_O,
  // Fault pin and amplifier
  input wire AMP_FAULT_N_O,
  input wire AMP_FAULT_N_OE_O,
  input wire AMP_ENABLE_O,
  // Error and shutdown pins
  input wire OVERVOLTAGE_I,
  input wire AMP_SHUTDOWN_N_I,
  input wire CLK_RATIO_BAD_I,
  input wire CLK_RATE_BAD_I,
  input wire CLK_STOPPED_I
);
  // ----------------------------------------
  // Helper counters
  // ----------------------------------------
  reg [3:0] run_reg;
  reg [3:0] quiet_reg;
  reg [15:0] held_reg;
  wire clk_bad = CLK_RATIO_BAD_I | CLK_RATE_BAD_I | CLK_STOPPED_I;
  wire rdy = run_reg == 4'hF;
  // Quiet gap tells a latched release from a clock release
  always @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      run_reg <= 4'h0;
      quiet_reg <= 4'h0;
      held_reg <= 16'h0;
    end else begin
      run_reg <= rdy ? run_reg : run_reg + 4'h1;
      quiet_reg <= clk_bad ? 4'h0 : (quiet_reg == 4'hF ? quiet_reg : quiet_reg + 4'h1);
      held_reg <= AMP_FAULT_N_OE_O ? held_reg + 16'h1 : 16'h0;
    end
  end
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!ARST_N_I);
  AST_ACK: assert property (CYC_I && STB_I && !ACK_O |=> ACK_O)
    else $error("bus request not acked");
  AST_ACK_ONE: assert property (ACK_O |=> !ACK_O)
    else $error("ack longer than one cycle");
  AST_DAT_HOLD: assert property ($changed(DAT_O) |-> $past(CYC_I && STB_I && !WE_I && !ACK_O))
    else $error("read data changed without a read");
  AST_OPEN_DRAIN: assert property (AMP_FAULT_N_O == 1'h0)
    else $error("fault pin data not low");
  AST_FAULT_MUTES: assert property (AMP_FAULT_N_OE_O |-> !AMP_ENABLE_O)
    else $error("amplifier runs during fault");
  AST_CLK_FAULT: assert property ((rdy && clk_bad) [*6] |-> AMP_FAULT_N_OE_O)
    else $error("clock error without fault");
  AST_OV_MUTE: assert property (OVERVOLTAGE_I [*6] |-> !AMP_ENABLE_O)
    else $error("amplifier runs on overvoltage");
  AST_SD_MUTE: assert property (!AMP_SHUTDOWN_N_I [*6] |-> !AMP_ENABLE_O)
    else $error("amplifier runs in shutdown");
  AST_TIMEOUT: assert property ($fell(AMP_FAULT_N_OE_O) && quiet_reg == 4'hF |-> held_reg >= FAULT_TIMEOUT_CYC - 2)
    else $error("latched fault released early");
  COV_CLK: cover property (clk_bad ##6 AMP_FAULT_N_OE_O);
  COV_REL: cover property ($fell(AMP_FAULT_N_OE_O) && quiet_reg == 4'hF);
  COV_RD: cover property (CYC_I && !WE_I && ACK_O);
endmodule // afm_fault_manager_sva

bind afm_fault_manager afm_fault_manager_sva #(.FAULT_TIMEOUT_CYC(FAULT_TIMEOUT_CYC)) sva_u (
  .CLK_I(CLK_I), .ARST_N_I(ARST_N_I), .CYC_I(CYC_I), .STB_I(STB_I), .WE_I(WE_I),
  .ACK_O(ACK_O), .DAT_O(DAT_O), .AMP_FAULT_N_O(AMP_FAULT_N_O), .AMP_FAULT_N_OE_O(AMP_FAULT_N_OE_O),
  .AMP_ENABLE_O(AMP_ENABLE_O), .OVERVOLTAGE_I(OVERVOLTAGE_I), .AMP_SHUTDOWN_N_I(AMP_SHUTDOWN_N_I),
  .CLK_RATIO_BAD_I(CLK_RATIO_BAD_I), .CLK_RATE_BAD_I(CLK_RATE_BAD_I), .CLK_STOPPED_I(CLK_STOPPED_I)
);

//--- bench/afm_sys_ctrl.sv
// System controller model on the fault and shutdown pins.
// Assumes the bench picks manual shutdown or the fault tie.
`timescale 1ns/10ps
module afm_sys_ctrl (
  // Clock
  input wire clk_i,
  // Device side
  input wire fault_oe_i,
  // Bench controls
  input wire tie_i,
  input wire sd_req_i,
  // Pin levels
  output wire fault_n_o,
  output reg sd_n_o = 1'h1
);
  // Pull-up wins whenever the device lets go
  assign fault_n_o = fault_oe_i ? 1'h0 : 1'h1;
  always @(posedge clk_i) begin
    sd_n_o <= tie_i ? fault_n_o : sd_req_i;
  end
endmodule // afm_sys_ctrl

//--- bench/afm_fault_manager_tb.sv
// Self-checking bench for the amplifier fault manager.
// Assumes short sim counts: timeout 20, DC run 2000, window 16.
`timescale 1ns/10ps
module afm_fault_manager_tb;
  logic CLK_I = 1'h0, ARST_N_I = 1'h0, CYC_I = 1'h0, STB_I = 1'h0, WE_I = 1'h0;
  logic [7:0] ADR_I = 8'h00;
  logic [3:0] SEL_I = 4'h0;
  logic [31:0] DAT_I = 32'h0, rd;
  logic MODE_HW_I = 1'h0, PBTL_I = 1'h0, FREQ_8X_I = 1'h0, tie = 1'h0, sd_req = 1'h1;
  logic OVERVOLTAGE_I = 1'h0, UNDERVOLTAGE_I = 1'h0, OVERCURRENT_I = 1'h0;
  logic OVERTEMP_I = 1'h0, OVERTEMP_HYST_I = 1'h0;
  logic CLK_RATIO_BAD_I = 1'h0, CLK_RATE_BAD_I = 1'h0, CLK_STOPPED_I = 1'h0;
  logic [1:0] PWM_POS_I = 2'h0, PWM_NEG_I = 2'h0;
  wire [31:0] DAT_O;
  wire ACK_O, AMP_FAULT_N_O, AMP_FAULT_N_OE_O, AMP_ENABLE_O, CFG_PBTL_O, CFG_FREQ_8X_O, IRQ_O;
  wire fault_n, AMP_SHUTDOWN_N_I;
  int fail_count = 0, checked = 0;
  afm_fault_manager #(.FAULT_TIMEOUT_CYC(20), .DC_PERSIST_CYC(2000), .DC_WIN_CYC(16)) dut_u (
    .CLK_I(CLK_I), .ARST_N_I(ARST_N_I), .CYC_I(CYC_I), .STB_I(STB_I), .WE_I(WE_I), .ADR_I(ADR_I),
    .SEL_I(SEL_I), .DAT_I(DAT_I), .DAT_O(DAT_O), .ACK_O(ACK_O), .MODE_HW_I(MODE_HW_I),
    .PBTL_I(PBTL_I), .FREQ_8X_I(FREQ_8X_I), .AMP_SHUTDOWN_N_I(AMP_SHUTDOWN_N_I),
    .OVERVOLTAGE_I(OVERVOLTAGE_I), .UNDERVOLTAGE_I(UNDERVOLTAGE_I), .OVERCURRENT_I(OVERCURRENT_I),
    .OVERTEMP_I(OVERTEMP_I), .OVERTEMP_HYST_I(OVERTEMP_HYST_I), .CLK_RATIO_BAD_I(CLK_RATIO_BAD_I),
    .CLK_RATE_BAD_I(CLK_RATE_BAD_I), .CLK_STOPPED_I(CLK_STOPPED_I), .PWM_POS_I(PWM_POS_I),
    .PWM_NEG_I(PWM_NEG_I), .AMP_FAULT_N_O(AMP_FAULT_N_O), .AMP_FAULT_N_OE_O(AMP_FAULT_N_OE_O),
    .AMP_ENABLE_O(AMP_ENABLE_O), .CFG_PBTL_O(CFG_PBTL_O), .CFG_FREQ_8X_O(CFG_FREQ_8X_O), .IRQ_O(IRQ_O));
  afm_sys_ctrl ctrl_u (.clk_i(CLK_I), .fault_oe_i(AMP_FAULT_N_OE_O), .tie_i(tie), .sd_req_i(sd_req),
    .fault_n_o(fault_n), .sd_n_o(AMP_SHUTDOWN_N_I));
  initial forever #50 CLK_I = ~CLK_I;
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task test_done;
    $display("checked %0d, fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // Run needs about 2800 cycles
  initial begin
    #2000000;
    fail_count++;
    test_done();
  end
  task step(input int n);
    repeat (n) @(posedge CLK_I);
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
      fail_count++;
    end
  endtask
  task wb(input logic we, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    CYC_I <= 1'h1;
    STB_I <= 1'h1;
    WE_I <= we;
    ADR_I <= a;
    DAT_I <= d;
    SEL_I <= s;
    @(posedge CLK_I);
    // Only the watchdog ends a missing ack
    while (ACK_O !== 1'h1) begin
      @(posedge CLK_I);
    end
    rd = DAT_O;
    CYC_I <= 1'h0;
    STB_I <= 1'h0;
    @(posedge CLK_I);
  endtask
  task rst(input logic hw, input logic pb);
    MODE_HW_I <= hw;
    PBTL_I <= pb;
    ARST_N_I <= 1'h0;
    step(12);
    ARST_N_I <= 1'h1;
    step(8);
  endtask
  task sd_pulse;
    sd_req <= 1'h0;
    step(4);
    sd_req <= 1'h1;
    step(8);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_regs;
    wb(0, 8'h00, 32'h0, 4'hF);
    chk(rd, 32'h1);
    wb(0, 8'h04, 32'h0, 4'hF);
    chk(rd, 32'h80);
    wb(0, 8'h10, 32'h0, 4'hF);
    chk(rd, 32'h0);
    wb(1, 8'h00, 32'h6, 4'h0);
    wb(0, 8'h00, 32'h0, 4'hF);
    chk(rd, 32'h1);
    wb(1, 8'h00, 32'h6, 4'h1);
    step(6);
    chk({AMP_ENABLE_O, CFG_PBTL_O, CFG_FREQ_8X_O}, 32'h3);
    wb(1, 8'h00, 32'h1, 4'h1);
    step(6);
    chk({AMP_ENABLE_O, CFG_PBTL_O, CFG_FREQ_8X_O}, 32'h4);
  endtask
  task t_clk;
    for (int i = 0; i < 3; i++) begin
      {CLK_STOPPED_I, CLK_RATE_BAD_I, CLK_RATIO_BAD_I} <= 3'(1 << i);
      step(8);
      chk(fault_n, 1'h0);
      wb(0, 8'h04, 32'h0, 4'hF);
      chk(rd[2], 1'h1);
      {CLK_STOPPED_I, CLK_RATE_BAD_I, CLK_RATIO_BAD_I} <= 3'h0;
      step(8);
      chk(fault_n, 1'h1);
    end
  endtask
  task t_volt;
    for (int i = 0; i < 2; i++) begin
      {UNDERVOLTAGE_I, OVERVOLTAGE_I} <= 2'(1 << i);
      step(8);
      chk({fault_n, AMP_ENABLE_O}, 32'h2);
      wb(0, 8'h04, 32'h0, 4'hF);
      chk(rd[i], 1'h1);
      {UNDERVOLTAGE_I, OVERVOLTAGE_I} <= 2'h0;
      step(8);
      chk(AMP_ENABLE_O, 1'h1);
    end
  endtask
  task t_oc;
    OVERCURRENT_I <= 1'h1;
    step(8);
    chk({fault_n, IRQ_O}, 32'h0);
    wb(1, 8'h0C, 32'h8, 4'h1);
    step(2);
    chk(IRQ_O, 1'h1);
    wb(0, 8'h0C, 32'h0, 4'hF);
    chk(rd, 32'h8);
    OVERCURRENT_I <= 1'h0;
    step(30);
    chk(fault_n, 1'h0);
    OVERCURRENT_I <= 1'h1;
    sd_pulse();
    step(30);
    chk(fault_n, 1'h0);
    OVERCURRENT_I <= 1'h0;
    sd_pulse();
    chk({fault_n, IRQ_O}, 32'h3);
    wb(1, 8'h08, 32'h8, 4'h1);
    step(2);
    chk(IRQ_O, 1'h0);
    wb(0, 8'h08, 32'h0, 4'hF);
    chk(rd, 32'h7);
    wb(1, 8'h0C, 32'h0, 4'h1);
  endtask
  task t_ot;
    OVERTEMP_HYST_I <= 1'h1;
    OVERTEMP_I <= 1'h1;
    step(8);
    OVERTEMP_I <= 1'h0;
    step(30);
    sd_pulse();
    step(30);
    chk(fault_n, 1'h0);
    OVERTEMP_HYST_I <= 1'h0;
    step(8);
    chk(fault_n, 1'h1);
  endtask
  task t_dc;
    PWM_POS_I <= 2'h2;
    step(1700);
    chk(fault_n, 1'h1);
    step(600);
    chk(fault_n, 1'h0);
    wb(0, 8'h04, 32'h0, 4'hF);
    chk(rd[4], 1'h1);
    PWM_POS_I <= 2'h0;
    step(30);
    // Toggle through the control bit, not the pin
    wb(1, 8'h00, 32'h0, 4'h1);
    wb(1, 8'h00, 32'h1, 4'h1);
    step(4);
    chk(fault_n, 1'h1);
  endtask
  task t_tie;
    tie <= 1'h1;
    OVERCURRENT_I <= 1'h1;
    step(8);
    chk(fault_n, 1'h0);
    OVERCURRENT_I <= 1'h0;
    step(60);
    chk(fault_n, 1'h1);
    tie <= 1'h0;
  endtask
  task t_hw;
    rst(1, 0);
    chk({CFG_PBTL_O, CFG_FREQ_8X_O}, 32'h0);
    rst(1, 1);
    chk({CFG_PBTL_O, CFG_FREQ_8X_O}, 32'h2);
    wb(1, 8'h00, 32'h4, 4'h1);
    step(6);
    chk({AMP_ENABLE_O, CFG_FREQ_8X_O}, 32'h2);
    wb(0, 8'h04, 32'h0, 4'hF);
    chk(rd[8], 1'h1);
  endtask
  initial begin
    rst(0, 0);
    t_regs();
    t_clk();
    t_volt();
    t_oc();
    t_ot();
    t_dc();
    t_tie();
    t_hw();
    test_done();
  end
endmodule // afm_fault_manager_tb
